//--- hdl/masr_pkg.sv
/*
  Constants for the motor-algorithm status register bank: register
  indices, byte addresses, field positions, reset values and bus codes.
  Assumes an AHB-Lite slave with 32-bit data, one word per register.
*/
package masr_pkg;

  // ==========================================================
  // register map (index, byte address = 4 * index)
  // ==========================================================
  localparam logic [7:0] IDX_DRIVE_STATUS = 8'he4;
  localparam logic [7:0] IDX_MOTOR_PARAMS = 8'he6;
  localparam logic [7:0] IDX_EXTRACT_STAT = 8'he8;
  localparam logic [7:0] IDX_DEVICE_CTRL = 8'hea;
  localparam logic [7:0] IDX_VIEW_CTRL = 8'hfc;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int ADDR_HI_LSB = 10;

  // ==========================================================
  // reset values
  // ==========================================================
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  // ==========================================================
  // drive_status fields
  // ==========================================================
  localparam int MOD_LSB = 16;
  localparam int DUTY_LSB = 4;
  localparam int COPY_DONE_BIT = 2;

  // ==========================================================
  // motor_parameter_results fields
  // ==========================================================
  localparam int RES_LSB = 24;
  localparam int BEMF_LSB = 16;
  localparam int IND_LSB = 8;

  // ==========================================================
  // extraction_status fields
  // ==========================================================
  localparam int RES_ST_BIT = 31;
  localparam int IND_ST_BIT = 30;
  localparam int BEMF_ST_BIT = 29;
  localparam int MECH_ST_BIT = 28;
  localparam int FREQ_LSB = 24;

  // ==========================================================
  // device_control fields and view control
  // ==========================================================
  localparam int EE_WRITE_BIT = 31;
  localparam int EE_READ_BIT = 30;
  localparam int CLR_FAULT_BIT = 29;
  localparam int CLR_RETRY_BIT = 28;
  localparam int KEY_LSB = 20;
  localparam int ANGLE_LSB = 11;
  localparam int TICKLE_BIT = 10;
  localparam int FREEZE_BIT = 0;

  // ==========================================================
  // bus codes and phases
  // ==========================================================
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [1:0]
  {
    MASR_IDLE = 2'h1,
    MASR_DATA = 2'h2
  } masr_phase_t;

endpackage : masr_pkg

//--- hdl/masr_hold.sv
/*
  One status word holder: loads the algorithm's word each cycle
  unless held. Assumes load and data come from the same clock.
*/
module masr_hold #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // update
  input wire logic load,
  input wire logic [W-1:0] d,
  // held word
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] val;
  } masr_hold_st_t;

  masr_hold_st_t st_q;
  masr_hold_st_t st_d;

  // ==========================================================
  // next state
  // ==========================================================
  always_comb
  begin
    st_d = st_q;
    if (load)
    begin
      st_d.val = d;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.val;

endmodule : masr_hold

//--- hdl/masr_top.sv
/*
  Motor-algorithm status register bank behind an AHB-Lite slave.
  Three status words follow the algorithm's outputs, a device control
  word drives control outputs, a view control word can hold the status
  words for a coherent read. Assumes all algorithm inputs are on mclk.
*/
module masr_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  // algorithm status
  input wire logic [15:0] applied_modulation_level,
  input wire logic [11:0] duty_command,
  input wire logic copy_done_flag,
  input wire logic [7:0] winding_resistance_est,
  input wire logic [7:0] back_emf_constant_est,
  input wire logic [7:0] winding_inductance_est,
  input wire logic resistance_meas_status,
  input wire logic inductance_meas_status,
  input wire logic back_emf_meas_status,
  input wire logic mechanical_meas_status,
  input wire logic [3:0] suggested_switching_freq,
  input wire logic tickle_clear,
  // device control
  output logic eeprom_write_req,
  output logic eeprom_read_req,
  output logic clear_faults_pulse,
  output logic clear_retry_pulse,
  output logic [7:0] write_access_key,
  output logic [8:0] forced_align_angle,
  output logic watchdog_tickle
);

  typedef struct packed {
    masr_pkg::masr_phase_t phase;
    logic wr;
    logic hit;
    logic [7:0] idx;
    logic rdy;
    logic [1:0] resp;
    logic [31:0] rdata;
    logic ee_wr;
    logic ee_rd;
    logic clr_flt;
    logic clr_cnt;
    logic [7:0] key;
    logic [8:0] angle;
    logic tickle;
    logic freeze;
  } masr_top_st_t;

  localparam masr_top_st_t ST_RESET = '{
    phase: masr_pkg::MASR_IDLE,
    wr: 1'b0,
    hit: 1'b0,
    idx: 8'h00,
    rdy: 1'b1,
    resp: masr_pkg::HRESP_OKAY,
    rdata: masr_pkg::STATUS_RESET,
    ee_wr: 1'b0,
    ee_rd: 1'b0,
    clr_flt: 1'b0,
    clr_cnt: 1'b0,
    key: 8'h00,
    angle: 9'h000,
    tickle: 1'b0,
    freeze: 1'b0
  };

  masr_top_st_t st_q;
  masr_top_st_t st_d;

  logic [31:0] drive_word;
  logic [31:0] motor_word;
  logic [31:0] extract_word;
  logic [31:0] drive_q;
  logic [31:0] motor_q;
  logic [31:0] extract_q;
  logic [31:0] ctrl_view;
  logic [31:0] read_mux;
  logic accept;

  // ==========================================================
  // status word assembly
  // ==========================================================
  always_comb
  begin
    drive_word = masr_pkg::STATUS_RESET;
    drive_word[masr_pkg::MOD_LSB +: 16] = applied_modulation_level;
    drive_word[masr_pkg::DUTY_LSB +: 12] = duty_command;
    drive_word[masr_pkg::COPY_DONE_BIT] = copy_done_flag;
    motor_word = masr_pkg::STATUS_RESET;
    motor_word[masr_pkg::RES_LSB +: 8] = winding_resistance_est;
    motor_word[masr_pkg::BEMF_LSB +: 8] = back_emf_constant_est;
    motor_word[masr_pkg::IND_LSB +: 8] = winding_inductance_est;
    extract_word = masr_pkg::STATUS_RESET;
    extract_word[masr_pkg::RES_ST_BIT] = resistance_meas_status;
    extract_word[masr_pkg::IND_ST_BIT] = inductance_meas_status;
    extract_word[masr_pkg::BEMF_ST_BIT] = back_emf_meas_status;
    extract_word[masr_pkg::MECH_ST_BIT] = mechanical_meas_status;
    extract_word[masr_pkg::FREQ_LSB +: 4] = suggested_switching_freq;
  end

  // ==========================================================
  // status holders, only the algorithm side loads them
  // ==========================================================
  masr_hold #(
    .W(32)
  ) u_drive (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(!st_q.freeze),
    .d(drive_word),
    .q(drive_q)
  );

  masr_hold #(
    .W(32)
  ) u_motor (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(!st_q.freeze),
    .d(motor_word),
    .q(motor_q)
  );

  masr_hold #(
    .W(32)
  ) u_extract (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(!st_q.freeze),
    .d(extract_word),
    .q(extract_q)
  );

  // ==========================================================
  // read view and decode
  // ==========================================================
  always_comb
  begin
    ctrl_view = masr_pkg::CTRL_RESET;
    ctrl_view[masr_pkg::EE_WRITE_BIT] = st_q.ee_wr;
    ctrl_view[masr_pkg::EE_READ_BIT] = st_q.ee_rd;
    ctrl_view[masr_pkg::TICKLE_BIT] = st_q.tickle;
    read_mux = masr_pkg::STATUS_RESET;
    if (st_q.hit)
    begin
      case (st_q.idx)
        masr_pkg::IDX_DRIVE_STATUS: read_mux = drive_q;
        masr_pkg::IDX_MOTOR_PARAMS: read_mux = motor_q;
        masr_pkg::IDX_EXTRACT_STAT: read_mux = extract_q;
        masr_pkg::IDX_DEVICE_CTRL: read_mux = ctrl_view;
        masr_pkg::IDX_VIEW_CTRL: read_mux[masr_pkg::FREEZE_BIT] = st_q.freeze;
        default: read_mux = masr_pkg::STATUS_RESET;
      endcase
    end
  end

  assign accept = hsel && hready && htrans[masr_pkg::HTRANS_ACTIVE_BIT];

  // ==========================================================
  // bus phases and control registers
  // ==========================================================
  always_comb
  begin
    st_d = st_q;
    st_d.clr_flt = 1'b0;
    st_d.clr_cnt = 1'b0;
    // tickle is cleared by the algorithm; a host write below wins
    if (tickle_clear)
    begin
      st_d.tickle = 1'b0;
    end
    case (st_q.phase)
      masr_pkg::MASR_IDLE:
      begin
        if (accept)
        begin
          st_d.phase = masr_pkg::MASR_DATA;
          st_d.rdy = 1'b0;
          st_d.wr = hwrite;
          st_d.idx = haddr[masr_pkg::IDX_MSB:masr_pkg::IDX_LSB];
          st_d.hit = (haddr[31:masr_pkg::ADDR_HI_LSB] == '0) && (haddr[1:0] == 2'h0);
        end
      end
      masr_pkg::MASR_DATA:
      begin
        st_d.phase = masr_pkg::MASR_IDLE;
        st_d.rdy = 1'b1;
        st_d.rdata = st_q.wr ? masr_pkg::STATUS_RESET : read_mux;
        if (st_q.wr && st_q.hit)
        begin
          // writes to status words fall to default and are dropped
          case (st_q.idx)
            masr_pkg::IDX_DEVICE_CTRL:
            begin
              st_d.ee_wr = hwdata[masr_pkg::EE_WRITE_BIT];
              st_d.ee_rd = hwdata[masr_pkg::EE_READ_BIT];
              st_d.clr_flt = hwdata[masr_pkg::CLR_FAULT_BIT];
              st_d.clr_cnt = hwdata[masr_pkg::CLR_RETRY_BIT];
              st_d.key = hwdata[masr_pkg::KEY_LSB +: 8];
              st_d.angle = hwdata[masr_pkg::ANGLE_LSB +: 9];
              if (hwdata[masr_pkg::TICKLE_BIT])
              begin
                st_d.tickle = 1'b1;
              end
            end
            masr_pkg::IDX_VIEW_CTRL:
            begin
              st_d.freeze = hwdata[masr_pkg::FREEZE_BIT];
            end
            default:
            begin
              st_d.freeze = st_q.freeze;
            end
          endcase
        end
      end
      default:
      begin
        st_d = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      st_q <= ST_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign hreadyout = st_q.rdy;
  assign hresp = st_q.resp;
  assign hrdata = st_q.rdata;
  assign eeprom_write_req = st_q.ee_wr;
  assign eeprom_read_req = st_q.ee_rd;
  assign clear_faults_pulse = st_q.clr_flt;
  assign clear_retry_pulse = st_q.clr_cnt;
  assign write_access_key = st_q.key;
  assign forced_align_angle = st_q.angle;
  assign watchdog_tickle = st_q.tickle;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic rd_data;
  logic wr_data;
  assign rd_data = (st_q.phase == masr_pkg::MASR_DATA) && !st_q.wr && st_q.hit;
  assign wr_data = (st_q.phase == masr_pkg::MASR_DATA) && st_q.wr && st_q.hit;

  answer_timing_a: assert property (
    accept && st_q.rdy |=> !hreadyout ##1 (hreadyout && hresp == 2'h0))
    else $error("answer not one wait state");

  drive_read_a: assert property (
    rd_data && st_q.idx == masr_pkg::IDX_DRIVE_STATUS |=> hrdata == $past(drive_q))
    else $error("drive status read mismatch");

  modulation_field_a: assert property (
    !st_q.freeze |=> drive_q[31:16] == $past(applied_modulation_level))
    else $error("modulation level not reported");

  duty_field_a: assert property (
    !st_q.freeze |=> drive_q[15:4] == $past(duty_command) && drive_q[3] == 1'b0)
    else $error("duty command not reported");

  copy_flag_a: assert property (
    !st_q.freeze && !copy_done_flag |=> !drive_q[2] && drive_q[1:0] == 2'h0)
    else $error("copy done set while copying");

  resistance_field_a: assert property (
    !st_q.freeze |=> motor_q[31:24] == $past(winding_resistance_est))
    else $error("resistance not reported");

  bemf_field_a: assert property (
    !st_q.freeze |=> motor_q[23:16] == $past(back_emf_constant_est))
    else $error("back emf constant not reported");

  inductance_field_a: assert property (
    !st_q.freeze |=> motor_q[15:8] == $past(winding_inductance_est) && motor_q[7:0] == 8'h00)
    else $error("inductance field wrong");

  meas_status_a: assert property (
    !st_q.freeze && resistance_meas_status && mechanical_meas_status
    |=> extract_q[31] && extract_q[28])
    else $error("measurement status lost");

  freq_field_a: assert property (
    !st_q.freeze |=> extract_q[27:24] == $past(suggested_switching_freq)
    && extract_q[23:0] == 24'h000000)
    else $error("frequency code field wrong");

  ctrl_write_a: assert property (
    wr_data && st_q.idx == masr_pkg::IDX_DEVICE_CTRL && hwdata[29]
    |=> clear_faults_pulse ##1 !clear_faults_pulse)
    else $error("clear faults pulse wrong");

  status_write_a: assert property (
    wr_data && st_q.idx == masr_pkg::IDX_DRIVE_STATUS && st_q.freeze
    |=> $stable(drive_q) && $stable(st_q.freeze))
    else $error("status word changed by write");

  tickle_set_a: assert property (
    wr_data && st_q.idx == masr_pkg::IDX_DEVICE_CTRL && hwdata[10] |=> watchdog_tickle)
    else $error("tickle write lost");

  drive_read_c: cover property (rd_data && st_q.idx == masr_pkg::IDX_DRIVE_STATUS);
  ctrl_write_c: cover property (wr_data && st_q.idx == masr_pkg::IDX_DEVICE_CTRL);
  freeze_set_c: cover property (st_q.freeze ##1 rd_data);

endmodule : masr_top

//--- dv/masr_top_tb_top.sv
/*
  Self-checking bench for the motor-algorithm status register bank.
  Assumes masr_pkg and masr_top are compiled first; the bench is the one
  AHB-Lite master and also drives the algorithm status inputs.
*/
module masr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  // ==========================================================
  logic mclk, rst_n, hsel, hwrite, hreadyout, cdone, rs, ls, ks, ms, tclr;
  logic ewr, erd, cfp, crp, tick, rd_pend;
  logic [31:0] haddr, hwdata, hrdata, held;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  logic [15:0] mod;
  logic [11:0] duty;
  logic [7:0] res, bemf, ind, key;
  logic [8:0] ang;
  logic [3:0] freq;
  logic [31:0] exp_q[$];
  int error_cnt, n_tests, seed, cyc, pulse_cnt;
  wire logic hready;

  assign hready = hreadyout;

  masr_top masr_top_inst (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .applied_modulation_level(mod), .duty_command(duty), .copy_done_flag(cdone),
    .winding_resistance_est(res), .back_emf_constant_est(bemf),
    .winding_inductance_est(ind), .resistance_meas_status(rs),
    .inductance_meas_status(ls), .back_emf_meas_status(ks),
    .mechanical_meas_status(ms), .suggested_switching_freq(freq),
    .tickle_clear(tclr), .eeprom_write_req(ewr), .eeprom_read_req(erd),
    .clear_faults_pulse(cfp), .clear_retry_pulse(crp), .write_access_key(key),
    .forced_align_angle(ang), .watchdog_tickle(tick)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // checking and closing
  // ==========================================================
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // result watcher: read data shows at the edge where hready returns high
  always @(posedge mclk)
  begin
    cyc++;
    if (rd_pend && hreadyout === 1'b1)
    begin
      check("hrdata", hrdata, exp_q.pop_front());
      check("hresp", {30'h0, hresp}, 32'h0);
      rd_pend = 1'b0;
    end
    if (rst_n === 1'b1 && hsel && htrans[1] && !hwrite && hreadyout === 1'b1)
      rd_pend = 1'b1;
    if (cfp === 1'b1)
      pulse_cnt++;
    if (crp === 1'b1)
      pulse_cnt++;
    if (cyc > 3000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================================
  // bus master and stimulus
  // ==========================================================
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge mclk);
    while (hready !== 1'b1)
      @(posedge mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1)
      @(posedge mclk);
  endtask : ahb

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    ahb(1'b0, idx, 32'h0);
  endtask : rd

  task automatic setin(input logic [31:0] a, input logic [31:0] b);
    mod <= a[31:16];
    duty <= a[15:4];
    cdone <= a[2];
    res <= b[31:24];
    bemf <= b[23:16];
    ind <= b[15:8];
    {rs, ls, ks, ms, freq} <= b[7:0];
    repeat (2) @(posedge mclk);
  endtask : setin

  function automatic logic [31:0] ds();
    return {mod, duty, 1'b0, cdone, 2'h0};
  endfunction : ds

  function automatic logic [31:0] mp();
    return {res, bemf, ind, 8'h00};
  endfunction : mp

  function automatic logic [31:0] es();
    return {rs, ls, ks, ms, freq, 24'h000000};
  endfunction : es

  task automatic rd_all;
    rd(masr_pkg::IDX_DRIVE_STATUS, ds());
    rd(masr_pkg::IDX_MOTOR_PARAMS, mp());
    rd(masr_pkg::IDX_EXTRACT_STAT, es());
  endtask : rd_all

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    seed = 12;
    {error_cnt, n_tests, cyc, pulse_cnt} = '0;
    {rst_n, rd_pend, hsel, hwrite, tclr} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    {mod, duty, cdone, res, bemf, ind, rs, ls, ks, ms, freq} = '0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd(masr_pkg::IDX_DRIVE_STATUS, masr_pkg::STATUS_RESET);
    rd(masr_pkg::IDX_MOTOR_PARAMS, masr_pkg::STATUS_RESET);
    rd(masr_pkg::IDX_EXTRACT_STAT, masr_pkg::STATUS_RESET);
    rd(masr_pkg::IDX_DEVICE_CTRL, masr_pkg::CTRL_RESET);
    repeat (8)
    begin
      setin($random(seed), $random(seed));
      rd_all();
    end
    // writes to the three status words change nothing
    setin(32'hffffffff, 32'hffffffff);
    ahb(1'b1, masr_pkg::IDX_DRIVE_STATUS, 32'h0);
    ahb(1'b1, masr_pkg::IDX_MOTOR_PARAMS, 32'h0);
    ahb(1'b1, masr_pkg::IDX_EXTRACT_STAT, 32'h0);
    rd_all();
    rd_all();
    // software only reads unlisted offsets, it never writes them
    rd(8'he7, 32'h0);
    rd(8'he5, 32'h0);
    // device control word
    ahb(1'b1, masr_pkg::IDX_DEVICE_CTRL, 32'hffffffff);
    rd(masr_pkg::IDX_DEVICE_CTRL, 32'hc0000400);
    check("pulses", pulse_cnt, 32'd2);
    check("eeprom", {29'h0, ewr, erd, tick}, 32'h7);
    tclr <= 1'b1;
    @(posedge mclk);
    tclr <= 1'b0;
    rd(masr_pkg::IDX_DEVICE_CTRL, 32'hc0000000);
    ahb(1'b1, masr_pkg::IDX_DEVICE_CTRL, 32'h0a5da800);
    check("key", {24'h0, key}, 32'ha5);
    check("angle", {23'h0, ang}, 32'h1b5);
    check("eeprom", {30'h0, ewr, erd}, 32'h0);
    // frozen view holds the words for a coherent read
    ahb(1'b1, masr_pkg::IDX_VIEW_CTRL, 32'h1);
    ahb(1'b1, masr_pkg::IDX_DRIVE_STATUS, 32'h0);
    held = ds();
    setin($random(seed), $random(seed));
    rd(masr_pkg::IDX_DRIVE_STATUS, held);
    ahb(1'b1, masr_pkg::IDX_VIEW_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    rd_all();
    // second reset in mid-run
    ahb(1'b1, masr_pkg::IDX_DEVICE_CTRL, 32'hc0000400);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    check("ctrl_after_reset", {29'h0, ewr, erd, tick}, 32'h0);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd_all();
    repeat (3) @(posedge mclk);
    check("queue", exp_q.size(), 32'h0);
    end_of_test();
  end

endmodule : masr_top_tb_top
